/* pkg/swsc_pkg.sv */
`default_nettype none
package swsc_pkg;
	localparam int CLK_MHZ = 25;
	localparam int LONG_RESET_US = 690;
	localparam int STD_RESET_US = 400;
	localparam int FAST_RESET_US = 48;
	localparam int STD_SAMPLE_US = 30;
	localparam int FAST_SAMPLE_US = 3;
	localparam int STD_HOLD_US = 30;
	localparam int FAST_HOLD_US = 3;
	localparam int STD_PDLY_US = 30;
	localparam int FAST_PDLY_US = 3;
	localparam int STD_PLOW_US = 120;
	localparam int FAST_PLOW_US = 12;
	localparam int STD_SLOT_MAX_US = 120;
	localparam int FAST_SLOT_MAX_US = 16;
	localparam int HYST_NS = 120;
	localparam int LPF_NS = 1000;
	localparam int STD_REH_NS = 5000;
	localparam int FAST_REH_NS = 2000;

	localparam int LONG_RESET_CYC = LONG_RESET_US * CLK_MHZ;
	localparam int STD_RESET_CYC = STD_RESET_US * CLK_MHZ;
	localparam logic [15:0] FAST_RESET_CYC = 16'(FAST_RESET_US * CLK_MHZ);
	localparam logic [15:0] STD_SAMPLE_CYC = 16'(STD_SAMPLE_US * CLK_MHZ);
	localparam logic [15:0] FAST_SAMPLE_CYC = 16'(FAST_SAMPLE_US * CLK_MHZ);
	localparam logic [15:0] STD_HOLD_CYC = 16'(STD_HOLD_US * CLK_MHZ);
	localparam logic [15:0] FAST_HOLD_CYC = 16'(FAST_HOLD_US * CLK_MHZ);
	localparam logic [15:0] STD_PDLY_CYC = 16'(STD_PDLY_US * CLK_MHZ);
	localparam logic [15:0] FAST_PDLY_CYC = 16'(FAST_PDLY_US * CLK_MHZ);
	localparam logic [15:0] STD_PLOW_CYC = 16'(STD_PLOW_US * CLK_MHZ);
	localparam logic [15:0] FAST_PLOW_CYC = 16'(FAST_PLOW_US * CLK_MHZ);
	localparam logic [15:0] STD_SLOT_MAX_CYC = 16'(STD_SLOT_MAX_US * CLK_MHZ);
	localparam logic [15:0] FAST_SLOT_MAX_CYC = 16'(FAST_SLOT_MAX_US * CLK_MHZ);
	localparam logic [7:0] HYST_CYC = 8'((HYST_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] LPF_CYC = 8'((LPF_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] STD_REH_CYC = 8'((STD_REH_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] FAST_REH_CYC = 8'((FAST_REH_NS * CLK_MHZ + 999) / 1000);

	localparam logic [7:0] CRC8_POLY = 8'h8C;
	localparam logic [15:0] CRC16_POLY = 16'hA001;

	typedef enum logic [2:0] {
		SWSC_IDLE = 3'b000,
		SWSC_LOW = 3'b001,
		SWSC_PWAIT = 3'b010,
		SWSC_PDRIVE = 3'b011,
		SWSC_PREL = 3'b100
	} swsc_state_t;

	function automatic logic [15:0] sat_inc(input logic [15:0] v);
		sat_inc = (v == 16'hFFFF) ? v : 16'(v + 16'h0001);
	endfunction

	function automatic logic [7:0] crc8_step(input logic [7:0] c, input logic d);
		crc8_step = {1'b0, c[7:1]} ^ ((c[0] ^ d) ? CRC8_POLY : 8'h00);
	endfunction

	function automatic logic [15:0] crc16_step(input logic [15:0] c, input logic d);
		crc16_step = {1'b0, c[15:1]} ^ ((c[0] ^ d) ? CRC16_POLY : 16'h0000);
	endfunction
endpackage
`default_nettype wire

/* pkg/swsc_crc_if.sv */
`default_nettype none
interface swsc_crc_if;
	logic clear;
	logic shift;
	logic din;
	logic [7:0] crc8;
	logic [15:0] crc16;
	modport engine(input clear, input shift, input din, output crc8, output crc16);
	modport user(output clear, output shift, output din, input crc8, input crc16);
endinterface
`default_nettype wire

/* logic/swsc_crc.sv */
`default_nettype none
module swsc_crc (
	input wire logic sys_clk,
	input wire logic rst,
	swsc_crc_if.engine bus
);
	logic [7:0] crc8_reg;
	logic [15:0] crc16_reg;
	wire logic [7:0] crc8_base;
	wire logic [15:0] crc16_base;

	// Clear and shift together shifts into a cleared generator
	assign crc8_base = bus.clear ? 8'h00 : crc8_reg;
	assign crc16_base = bus.clear ? 16'h0000 : crc16_reg;
	assign bus.crc8 = crc8_reg;
	assign bus.crc16 = crc16_reg;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			crc8_reg <= 8'h00;
			crc16_reg <= 16'h0000;
		end else if (bus.shift) begin
			crc8_reg <= swsc_pkg::crc8_step(crc8_base, bus.din);
			crc16_reg <= swsc_pkg::crc16_step(crc16_base, bus.din);
		end else begin
			crc8_reg <= crc8_base;
			crc16_reg <= crc16_base;
		end
	end
endmodule
`default_nettype wire

/* logic/swsc_line_filter.sv */
`default_nettype none
module swsc_line_filter (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic line_in,
	input wire logic fast,
	output logic line_high,
	output logic fall_pulse,
	output logic rise_pulse
);
	logic [2:0] sync_reg;
	logic filt_reg;
	logic [7:0] cnt_reg;
	logic [7:0] hold_reg;
	logic fall_reg;
	logic rise_reg;
	wire logic agree;
	wire logic differs;
	wire logic [7:0] thr;
	wire logic take;
	wire logic [7:0] cnt_next;
	wire logic [7:0] hold_next;

	assign agree = sync_reg[1] == sync_reg[2];
	assign differs = agree && (sync_reg[2] != filt_reg);
	// Falls need the low to last longer at standard speed
	assign thr = (filt_reg && !fast) ? 8'(swsc_pkg::HYST_CYC + swsc_pkg::LPF_CYC)
		: swsc_pkg::HYST_CYC;
	// A low still present when hold-off ends is a new fall
	assign take = differs && (cnt_reg >= thr) && (!filt_reg || hold_reg == 8'h00);
	assign cnt_next = take ? 8'h00 : differs ? ((cnt_reg == 8'hFF) ? cnt_reg
		: 8'(cnt_reg + 8'h01)) : agree ? 8'h00 : cnt_reg;
	assign hold_next = (take && !filt_reg)
		? (fast ? swsc_pkg::FAST_REH_CYC : swsc_pkg::STD_REH_CYC)
		: (hold_reg != 8'h00) ? 8'(hold_reg - 8'h01) : hold_reg;
	assign line_high = filt_reg;
	assign fall_pulse = fall_reg;
	assign rise_pulse = rise_reg;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sync_reg <= 3'h7;
			filt_reg <= 1'b1;
			cnt_reg <= 8'h00;
			hold_reg <= 8'h00;
			fall_reg <= 1'b0;
			rise_reg <= 1'b0;
		end else begin
			sync_reg <= {sync_reg[1:0], line_in};
			filt_reg <= take ? sync_reg[2] : filt_reg;
			cnt_reg <= cnt_next;
			hold_reg <= hold_next;
			fall_reg <= take && filt_reg;
			rise_reg <= take && !filt_reg;
		end
	end
endmodule
`default_nettype wire

/* logic/swsc_slave_link.sv */
`default_nettype none
// Overview of operation
// - Master starts slots; device starts only presence
// - Standard timing unless fast speed was set
// - Reset of 690 us clears fast speed
// - Short reset at fast speed keeps it
// - After reset rise, wait, then drive presence
// - Ready for data right after presence ends
// - One bit per slot, either direction
// - Slot timer starts at each accepted fall
// - Recovery hold-off after each rise
// - Read zero pulls low until timer ends
// - Extra fall filtering at standard speed only
// - Shallow negative glitches are not edges
// - Ignore glitches inside hold-off, not beyond
// - ROM check is 8-bit CRC, uninverted
// - 16-bit CRC, always sent inverted
// - Memory read first pass: clear, command, address, data
// - Memory read later passes: clear, data only
// - Scratchpad write CRC sent at offset end
// - Scratchpad read CRC includes status byte
// - Fast-speed commands set speed until long reset
module swsc_slave_link #(
	parameter int STD_RESET_CYC = swsc_pkg::STD_RESET_CYC,
	parameter int LONG_RESET_CYC = swsc_pkg::LONG_RESET_CYC
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic line_in,
	output logic line_out,
	output logic line_oe,
	input wire logic fast_set,
	output logic fast_speed_flag,
	output logic link_ready,
	output logic reset_seen,
	output logic presence_active,
	input wire logic tx_valid,
	input wire logic tx_bit,
	output logic bit_done,
	output logic bit_value,
	output logic bit_was_read,
	output logic rx_byte_valid,
	output logic [7:0] rx_byte,
	output logic [2:0] bit_index,
	output logic slot_fault,
	input wire logic crc_clear,
	input wire logic crc_en,
	output logic [7:0] crc8_value,
	output logic [15:0] crc16_tx
);
	swsc_pkg::swsc_state_t state_reg;
	swsc_pkg::swsc_state_t state_next;
	logic [15:0] cnt_reg;
	logic [15:0] cnt_next;
	logic fast_reg;
	logic fast_next;
	logic ready_reg;
	logic ready_next;
	logic drive_reg;
	logic drive_next;
	logic read_reg;
	logic read_next;
	logic val_reg;
	logic val_next;
	logic done_reg;
	logic done_next;
	logic fault_reg;
	logic fault_next;
	logic rst_seen_reg;
	logic rst_seen_next;
	logic rxv_reg;
	logic rxv_next;
	logic [7:0] byte_reg;
	logic [7:0] byte_next;
	logic [2:0] idx_reg;
	logic [2:0] idx_next;

	wire logic line_high;
	wire logic fall_pulse;
	wire logic rise_pulse;
	wire logic [15:0] sample_cyc;
	wire logic [15:0] hold_cyc;
	wire logic [15:0] pdly_cyc;
	wire logic [15:0] plow_cyc;
	wire logic [15:0] slot_max_cyc;
	wire logic [15:0] reset_cyc;
	wire logic sample_hit;
	wire logic hold_hit;
	wire logic reset_hit;
	wire logic long_hit;
	wire logic fault_hit;
	wire logic read_req;
	wire logic slot_end;
	wire logic good_bit;

	swsc_crc_if crc_bus();

	swsc_line_filter u_filter (
		.sys_clk(sys_clk),
		.rst(rst),
		.line_in(line_in),
		.fast(fast_reg),
		.line_high(line_high),
		.fall_pulse(fall_pulse),
		.rise_pulse(rise_pulse)
	);

	swsc_crc u_crc (
		.sys_clk(sys_clk),
		.rst(rst),
		.bus(crc_bus.engine)
	);

	// Timing set follows the current speed
	assign sample_cyc = fast_reg ? swsc_pkg::FAST_SAMPLE_CYC : swsc_pkg::STD_SAMPLE_CYC;
	assign hold_cyc = fast_reg ? swsc_pkg::FAST_HOLD_CYC : swsc_pkg::STD_HOLD_CYC;
	assign pdly_cyc = fast_reg ? swsc_pkg::FAST_PDLY_CYC : swsc_pkg::STD_PDLY_CYC;
	assign plow_cyc = fast_reg ? swsc_pkg::FAST_PLOW_CYC : swsc_pkg::STD_PLOW_CYC;
	assign slot_max_cyc = fast_reg ? swsc_pkg::FAST_SLOT_MAX_CYC
		: swsc_pkg::STD_SLOT_MAX_CYC;
	assign reset_cyc = fast_reg ? swsc_pkg::FAST_RESET_CYC : 16'(STD_RESET_CYC);

	assign sample_hit = cnt_reg == sample_cyc;
	assign hold_hit = cnt_reg >= hold_cyc;
	assign reset_hit = cnt_reg >= reset_cyc;
	// Fast reset threshold lies below the keep limit
	assign long_hit = cnt_reg >= 16'(LONG_RESET_CYC);
	assign fault_hit = cnt_reg > slot_max_cyc;
	assign read_req = tx_valid && ready_reg;
	assign slot_end = (state_reg == swsc_pkg::SWSC_LOW) && rise_pulse;
	assign good_bit = slot_end && !reset_hit && !fault_hit && ready_reg;

	// Bits enter the generators in line order
	assign crc_bus.clear = crc_clear;
	assign crc_bus.shift = good_bit && crc_en;
	assign crc_bus.din = val_reg;

	assign line_out = 1'b0;
	assign line_oe = drive_reg;
	assign fast_speed_flag = fast_reg;
	assign link_ready = ready_reg;
	assign reset_seen = rst_seen_reg;
	assign presence_active = state_reg == swsc_pkg::SWSC_PDRIVE;
	assign bit_done = done_reg;
	assign bit_value = val_reg;
	assign bit_was_read = read_reg;
	assign rx_byte_valid = rxv_reg;
	assign rx_byte = byte_reg;
	assign bit_index = idx_reg;
	assign slot_fault = fault_reg;
	assign crc8_value = crc_bus.crc8;
	assign crc16_tx = ~crc_bus.crc16;

	always_comb begin
		state_next = state_reg;
		cnt_next = swsc_pkg::sat_inc(cnt_reg);
		fast_next = fast_reg;
		ready_next = ready_reg;
		drive_next = drive_reg;
		read_next = read_reg;
		val_next = val_reg;
		done_next = 1'b0;
		fault_next = 1'b0;
		rst_seen_next = 1'b0;
		rxv_next = 1'b0;
		byte_next = byte_reg;
		idx_next = idx_reg;
		case (state_reg)
			swsc_pkg::SWSC_IDLE,
			swsc_pkg::SWSC_PWAIT: begin
				if (fall_pulse) begin
					// Every slot opens on a master fall
					state_next = swsc_pkg::SWSC_LOW;
					cnt_next = 16'h0000;
					read_next = read_req;
					drive_next = read_req && !tx_bit;
					val_next = read_req ? tx_bit : 1'b1;
				end else if (state_reg == swsc_pkg::SWSC_PWAIT && cnt_reg >= pdly_cyc) begin
					state_next = swsc_pkg::SWSC_PDRIVE;
					cnt_next = 16'h0000;
					drive_next = 1'b1;
				end
			end
			swsc_pkg::SWSC_LOW: begin
				if (sample_hit && !read_reg) begin
					val_next = line_high;
				end
				if (drive_reg && hold_hit) begin
					drive_next = 1'b0;
				end
				if (rise_pulse) begin
					cnt_next = 16'h0000;
					drive_next = 1'b0;
					if (reset_hit) begin
						state_next = swsc_pkg::SWSC_PWAIT;
						rst_seen_next = 1'b1;
						ready_next = 1'b0;
						idx_next = 3'h0;
						if (long_hit) begin
							fast_next = 1'b0;
						end
					end else if (fault_hit) begin
						state_next = swsc_pkg::SWSC_IDLE;
						fault_next = 1'b1;
					end else begin
						state_next = swsc_pkg::SWSC_IDLE;
						done_next = ready_reg;
					end
				end
			end
			swsc_pkg::SWSC_PDRIVE: begin
				if (cnt_reg >= plow_cyc) begin
					state_next = swsc_pkg::SWSC_PREL;
					drive_next = 1'b0;
				end
			end
			swsc_pkg::SWSC_PREL: begin
				if (rise_pulse || line_high) begin
					state_next = swsc_pkg::SWSC_IDLE;
					ready_next = 1'b1;
				end
			end
			default: begin
				state_next = swsc_pkg::SWSC_IDLE;
				drive_next = 1'b0;
			end
		endcase
		if (good_bit) begin
			byte_next = {val_reg, byte_reg[7:1]};
			idx_next = 3'(idx_reg + 3'h1);
			rxv_next = idx_reg == 3'h7;
		end
		if (fast_set) begin
			fast_next = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_reg <= swsc_pkg::SWSC_IDLE;
			cnt_reg <= 16'h0000;
			fast_reg <= 1'b0;
			ready_reg <= 1'b0;
			drive_reg <= 1'b0;
			read_reg <= 1'b0;
			val_reg <= 1'b1;
			done_reg <= 1'b0;
			fault_reg <= 1'b0;
			rst_seen_reg <= 1'b0;
			rxv_reg <= 1'b0;
			byte_reg <= 8'h00;
			idx_reg <= 3'h0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			fast_reg <= fast_next;
			ready_reg <= ready_next;
			drive_reg <= drive_next;
			read_reg <= read_next;
			val_reg <= val_next;
			done_reg <= done_next;
			fault_reg <= fault_next;
			rst_seen_reg <= rst_seen_next;
			rxv_reg <= rxv_next;
			byte_reg <= byte_next;
			idx_reg <= idx_next;
		end
	end
endmodule
`default_nettype wire

/* sim/swsc_master_model.sv */
`default_nettype none
module swsc_master_model (
	input wire logic sys_clk,
	input wire logic line,
	output logic pull_low
);
	timeunit 1ns;
	timeprecision 1ns;
	initial pull_low = 1'b0;
	// Line low for lo cycles, sampled at smp, whole slot is tot cycles
	task automatic slot(input int lo, input int smp, input int tot, output logic seen);
		seen = 1'b1;
		for (int i = 0; i < tot; i++) begin
			@(posedge sys_clk);
			#1;
			pull_low = (i < lo);
			if (i == smp) seen = line;
		end
	endtask
endmodule
`default_nettype wire

/* sim/swsc_checker.sv */
`default_nettype none
module swsc_checker #(
	parameter int STD_RESET_CYC = 3200,
	parameter int LONG_RESET_CYC = 4000
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic line_out,
	input wire logic line_oe,
	input wire logic fast_set,
	input wire logic fast_speed_flag,
	input wire logic link_ready,
	input wire logic reset_seen,
	input wire logic presence_active,
	input wire logic tx_valid,
	input wire logic bit_done,
	input wire logic rx_byte_valid,
	input wire logic slot_fault,
	input wire logic crc_clear,
	input wire logic [7:0] crc8_value,
	input wire logic [15:0] crc16_tx
);
	logic [15:0] oe_cnt_reg;
	logic [15:0] oe_cnt_next;
	logic [15:0] plow;
	logic [15:0] hold;
	assign oe_cnt_next = line_oe ? 16'(oe_cnt_reg + 16'h0001) : 16'h0000;
	assign plow = fast_speed_flag ? swsc_pkg::FAST_PLOW_CYC : swsc_pkg::STD_PLOW_CYC;
	assign hold = fast_speed_flag ? swsc_pkg::FAST_HOLD_CYC : swsc_pkg::STD_HOLD_CYC;
	always_ff @(posedge sys_clk) begin
		if (rst) oe_cnt_reg <= 16'h0000;
		else oe_cnt_reg <= oe_cnt_next;
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence s_clear_idle;
		crc_clear ##1 !bit_done;
	endsequence
	sequence s_pres_end;
		$fell(presence_active);
	endsequence
	property p_drive_low;
		line_oe |-> line_out == 1'b0;
	endproperty
	a_drive_low: assert property (p_drive_low) else $error("line driven high");
	property p_oe_cause;
		line_oe |-> presence_active || $past(presence_active) || tx_valid;
	endproperty
	a_oe_cause: assert property (p_oe_cause) else $error("pull low without cause");
	property p_oe_len;
		$fell(line_oe) |-> (oe_cnt_reg + 2 >= plow && oe_cnt_reg <= plow + 2)
			|| (oe_cnt_reg + 2 >= hold && oe_cnt_reg <= hold + 2);
	endproperty
	a_oe_len: assert property (p_oe_len) else $error("pull low length wrong");
	property p_fast_set;
		fast_set |=> fast_speed_flag;
	endproperty
	a_fast_set: assert property (p_fast_set) else $error("fast speed not entered");
	property p_fast_drop;
		$fell(fast_speed_flag) |-> (reset_seen || $past(reset_seen) || $past(reset_seen, 2))
			or ##[1:2] reset_seen;
	endproperty
	a_fast_drop: assert property (p_fast_drop) else $error("speed dropped without reset");
	property p_ready;
		s_pres_end |-> ##[0:20] link_ready;
	endproperty
	a_ready: assert property (p_ready) else $error("not ready after presence");
	property p_reset;
		reset_seen |=> !reset_seen && !link_ready;
	endproperty
	a_reset: assert property (p_reset) else $error("ready kept over reset");
	property p_byte;
		rx_byte_valid |-> bit_done;
	endproperty
	a_byte: assert property (p_byte) else $error("byte without bit");
	property p_fault;
		slot_fault |-> !bit_done ##1 !bit_done;
	endproperty
	a_fault: assert property (p_fault) else $error("bit from faulty slot");
	property p_crc_clr;
		s_clear_idle |-> crc8_value == 8'h00 && crc16_tx == 16'hFFFF;
	endproperty
	a_crc_clr: assert property (p_crc_clr) else $error("crc not cleared");
	property p_crc_hold;
		$changed(crc8_value) || $changed(crc16_tx) |-> bit_done || $past(crc_clear);
	endproperty
	a_crc_hold: assert property (p_crc_hold) else $error("crc moved without bit");
endmodule
bind swsc_slave_link swsc_checker #(
	.STD_RESET_CYC(STD_RESET_CYC),
	.LONG_RESET_CYC(LONG_RESET_CYC)
) i_chk (.sys_clk, .rst, .line_out, .line_oe, .fast_set, .fast_speed_flag, .link_ready,
	.reset_seen, .presence_active, .tx_valid, .bit_done, .rx_byte_valid, .slot_fault,
	.crc_clear, .crc8_value, .crc16_tx);
`default_nettype wire

/* sim/testbench.sv */
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic fast_set = 1'b0, tx_valid = 1'b0, tx_bit = 1'b0, crc_clear = 1'b0, crc_en = 1'b0;
	logic pull_low, line_in, line_out, line_oe, fast_speed_flag, link_ready, reset_seen;
	logic presence_active, bit_done, bit_value, bit_was_read, rx_byte_valid, slot_fault;
	logic [7:0] rx_byte, crc8_value, e8;
	logic [2:0] bit_index;
	logic [15:0] crc16_tx, e16;
	int err_total = 0, num_checks = 0, n_done = 0, n_rst = 0, n_fault = 0;
	assign line_in = ~(pull_low | (line_oe === 1'b1));
	swsc_slave_link #(.STD_RESET_CYC(3200), .LONG_RESET_CYC(4000)) i_dut (.sys_clk, .rst,
		.line_in, .line_out, .line_oe, .fast_set, .fast_speed_flag, .link_ready, .reset_seen,
		.presence_active, .tx_valid, .tx_bit, .bit_done, .bit_value, .bit_was_read,
		.rx_byte_valid, .rx_byte, .bit_index, .slot_fault, .crc_clear, .crc_en, .crc8_value,
		.crc16_tx);
	swsc_master_model i_master (.sys_clk, .line(line_in), .pull_low);
	always #20 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		if (bit_done === 1'b1) n_done++;
		if (reset_seen === 1'b1) n_rst++;
		if (slot_fault === 1'b1) n_fault++;
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic bus_reset(input int lo, input logic f);
		logic s;
		int r0;
		r0 = n_rst;
		// Reset high long enough for mixed buses
		i_master.slot(lo, lo + (f ? 150 : 1750), lo + (f ? 1250 : 12050), s);
		chk(16'(s), 16'h0000, "presence");
		chk(16'(n_rst - r0), 16'h0001, "reset count");
		chk(16'(link_ready), 16'h0001, "ready");
		chk(16'(fast_speed_flag), 16'(f), "speed");
	endtask
	task automatic clr();
		crc_clear = 1'b1;
		@(posedge sys_clk);
		#1;
		crc_clear = 1'b0;
		crc_en = 1'b1;
		e8 = 8'h00;
		e16 = 16'h0000;
	endtask
	task automatic xbyte(input logic [7:0] d, input logic f, input logic rd);
		logic s;
		int d0;
		d0 = n_done;
		tx_valid = rd;
		for (int i = 0; i < 8; i++) begin
			tx_bit = d[i];
			i_master.slot((rd || d[i]) ? (f ? 25 : 150) : (f ? 200 : 1500), f ? 50 : 500,
				f ? 300 : 2000, s);
			if (rd) chk(16'(s), 16'(d[i]), "read bit");
			e8 = (e8 >> 1) ^ ((e8[0] ^ d[i]) ? 8'h8C : 8'h00);
			e16 = (e16 >> 1) ^ ((e16[0] ^ d[i]) ? 16'hA001 : 16'h0000);
		end
		tx_valid = 1'b0;
		chk(16'(n_done - d0), 16'h0008, "bits");
		chk(16'(rx_byte), 16'(d), "byte");
		chk(16'(bit_was_read), 16'(rd), "direction");
		chk(16'(bit_value), 16'(d[7]), "last bit");
		chk(16'(bit_index), 16'h0000, "bit index");
		chk(16'(crc8_value), 16'(e8), "crc8");
		chk(crc16_tx, ~e16, "crc16");
	endtask
	task automatic glitch(input int lo, input int tot, input int bits);
		logic s;
		int d0;
		d0 = n_done;
		i_master.slot(lo, 0, tot, s);
		chk(16'(n_done - d0), 16'(bits), "glitch bits");
	endtask
	task automatic t_std();
		bus_reset(3400, 1'b0);
		clr();
		xbyte(8'hA5, 1'b0, 1'b0);
		xbyte(8'h96, 1'b0, 1'b1);
	endtask
	task automatic t_fast();
		fast_set = 1'b1;
		@(posedge sys_clk);
		#1;
		fast_set = 1'b0;
		chk(16'(fast_speed_flag), 16'h0001, "fast");
		clr();
		xbyte(8'h3C, 1'b1, 1'b0);
		clr();
		xbyte(8'h5A, 1'b1, 1'b1);
		bus_reset(1500, 1'b1);
		glitch(15, 300, 1);
		glitch(2, 300, 0);
		bus_reset(4200, 1'b0);
	endtask
	task automatic t_glitch();
		int f0;
		f0 = n_fault;
		glitch(15, 300, 0);
		glitch(150, 170, 1);
		glitch(60, 2000, 0);
		glitch(150, 170, 1);
		glitch(250, 2000, 1);
		glitch(3100, 3400, 0);
		chk(16'(n_fault - f0), 16'h0001, "slot fault");
	endtask
	initial begin
		repeat (90000) @(posedge sys_clk);
		err_total++;
		stop_test();
	end
	initial begin
		repeat (6) @(posedge sys_clk);
		#1;
		rst = 1'b0;
		t_std();
		t_fast();
		t_glitch();
		stop_test();
	end
endmodule
`default_nettype wire
